/* File: hw/async_serial_ext_ctrl_brg.sv */
// Serial extension control top: registers, modem auto-enable, break, clocks
`timescale 1ns/1ns
`default_nettype none
module async_serial_ext_ctrl_brg
  import serial_ext_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic carrierDetectInN,
  input wire logic clearToSendInN,
  input wire logic ioStopMode,
  input wire logic errorFlagResetWr0,
  input wire logic errorFlagResetWr1,
  input wire logic rxIntEnable0,
  input wire logic rxIntEnable1,
  input wire logic [1:0] divideRatioSel,
  input wire logic [5:0] speedSelect,
  input wire logic [1:0] serialClockPinIn,
  input wire logic [1:0] headValid,
  input wire logic [15:0] headData,
  input wire logic [1:0] headStopZero,
  input wire logic [1:0] headOverrun,
  input wire logic [1:0] headParityErr,
  input wire logic [1:0] txSerialOut,
  input wire logic txHoldingEmptyRaw,
  output logic rxHoldReset0,
  output logic txHoldingEmpty0,
  output logic [1:0] serialTxPin,
  output logic [1:0] serialClockPinOut,
  output logic [1:0] serialClockPinOe,
  output logic [1:0] bitClockTick,
  output logic [1:0] breakDetectEnable,
  output logic [1:0] framingErrFlag,
  output logic [1:0] rxIntReq
);
  logic [7:0] ext0;
  logic [7:0] ext1;
  logic [15:0] tc0;
  logic [15:0] tc1;
  logic [7:0] next_ext0;
  logic [7:0] next_ext1;
  logic [15:0] next_tc0;
  logic [15:0] next_tc1;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  logic dcdMeta;
  logic dcdSync;
  logic dcdPrev;
  logic dcdRiseSticky;
  logic next_dcdRiseSticky;
  logic [1:0] brgTick;
  logic [1:0] srcTick;
  logic [1:0] bitTickW;
  logic [1:0] extClkPrev;
  logic [1:0] next_framingErr;
  logic [1:0] next_brkDet;
  logic dcdHold;
  logic [1:0] errClear;
  logic [1:0] txPinNext;
  logic [1:0] clkOutNext;
  logic [1:0] clkOeNext;
  logic [1:0] rxIntNext;
  logic rxHoldNext;
  logic txEmptyNext;
  logic clkToggle0;
  logic clkToggle1;

  logic apbWrite;
  logic apbRead;
  assign apbWrite = psel && penable && pwrite && !pready;
  assign apbRead = psel && penable && !pwrite && !pready;

  function automatic logic [7:0] wrByte(input logic [7:0] old, input logic [31:0] d,
                                        input logic en);
    wrByte = en ? d[7:0] : old;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == ADDR_EXT0) || (a == ADDR_EXT1) || (a == ADDR_TC0_LO) ||
             (a == ADDR_TC0_HI) || (a == ADDR_TC1_LO) || (a == ADDR_TC1_HI) ||
             (a == ADDR_CTRL0) || (a == ADDR_CTRL1) || (a == ADDR_STAT);
  endfunction

  // Carrier auto-enable hold for channel 0
  assign dcdHold = !ext0[BIT_DCD_DIS] && dcdSync;
  assign errClear[0] = errorFlagResetWr0 || ioStopMode || dcdHold;
  assign errClear[1] = errorFlagResetWr1 || ioStopMode;

  // Register file; break-detect bit is hardware owned and not writable
  always_comb begin
    next_ext0 = ext0;
    next_ext1 = ext1;
    next_tc0 = tc0;
    next_tc1 = tc1;
    next_prdata = prdata;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    if (apbWrite) begin
      next_pready = 1'b1;
      next_pslverr = !mapped(paddr);
      unique case (paddr)
        ADDR_EXT0: next_ext0 = wrByte(ext0, pwdata & 32'h0000007d, pstrb[0]);
        ADDR_EXT1: next_ext1 = wrByte(ext1, pwdata & 32'h0000001d, pstrb[0]);
        ADDR_TC0_LO: next_tc0[7:0] = wrByte(tc0[7:0], pwdata, pstrb[0]);
        ADDR_TC0_HI: next_tc0[15:8] = wrByte(tc0[15:8], pwdata, pstrb[0]);
        ADDR_TC1_LO: next_tc1[7:0] = wrByte(tc1[7:0], pwdata, pstrb[0]);
        ADDR_TC1_HI: next_tc1[15:8] = wrByte(tc1[15:8], pwdata, pstrb[0]);
        default: ;
      endcase
      if (pstrb[0] && paddr == ADDR_EXT0) begin
        next_ext0[BIT_BRK_DET] = ext0[BIT_BRK_DET];
      end
      if (pstrb[0] && paddr == ADDR_EXT1) begin
        next_ext1[BIT_BRK_DET] = ext1[BIT_BRK_DET];
      end
    end else if (apbRead) begin
      next_pready = 1'b1;
      next_pslverr = !mapped(paddr);
      unique case (paddr)
        ADDR_EXT0: next_prdata = {24'h000000, ext0};
        ADDR_EXT1: next_prdata = {24'h000000, ext1};
        ADDR_TC0_LO: next_prdata = {24'h000000, tc0[7:0]};
        ADDR_TC0_HI: next_prdata = {24'h000000, tc0[15:8]};
        ADDR_TC1_LO: next_prdata = {24'h000000, tc1[7:0]};
        ADDR_TC1_HI: next_prdata = {24'h000000, tc1[15:8]};
        // Pin levels stay visible whatever the disable bits say
        ADDR_CTRL0: next_prdata = {31'h00000000, clearToSendInN};
        ADDR_CTRL1: next_prdata = 32'h00000000;
        ADDR_STAT: next_prdata = {29'h00000000, dcdRiseSticky, dcdSync, txHoldingEmpty0};
        default: next_prdata = RESP_UNMAPPED;
      endcase
    end
    // Break detect: set beats clear so a head event is never lost
    next_brkDet[0] = ext0[BIT_BRK_DET];
    next_brkDet[1] = ext1[BIT_BRK_DET];
    next_framingErr = framingErrFlag;
    for (int c = 0; c < 2; c++) begin
      if (errClear[c]) begin
        next_brkDet[c] = 1'b0;
        next_framingErr[c] = 1'b0;
      end
      if (headValid[c] && headStopZero[c]) begin
        next_framingErr[c] = 1'b1;
        if (headData[c*8 +: 8] == 8'h00 && breakDetectEnable[c]) begin
          next_brkDet[c] = 1'b1;
        end
      end
    end
    next_ext0[BIT_BRK_DET] = next_brkDet[0];
    next_ext1[BIT_BRK_DET] = next_brkDet[1];
    // Status read clears the sticky edge; a new edge in the same cycle wins
    next_dcdRiseSticky = dcdRiseSticky;
    if (apbRead && paddr == ADDR_STAT) begin
      next_dcdRiseSticky = 1'b0;
    end
    if (dcdSync && !dcdPrev) begin
      next_dcdRiseSticky = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ext0 <= EXT_RESET;
      ext1 <= EXT_RESET;
      tc0 <= '0;
      tc1 <= '0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      dcdRiseSticky <= 1'b0;
      framingErrFlag <= '0;
    end else begin
      ext0 <= next_ext0;
      ext1 <= next_ext1;
      tc0 <= next_tc0;
      tc1 <= next_tc1;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      dcdRiseSticky <= next_dcdRiseSticky;
      framingErrFlag <= next_framingErr;
    end
  end

  // Carrier pin synchroniser; first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dcdMeta <= 1'b1;
      dcdSync <= 1'b1;
      dcdPrev <= 1'b1;
    end else begin
      dcdMeta <= carrierDetectInN;
      dcdSync <= dcdMeta;
      dcdPrev <= dcdSync;
    end
  end

  baud_gen #() u_brg0 (
    .clk_sys(clk_sys),
    .reset(reset),
    .mode(ext0[BIT_BAUD_GEN_MODE]),
    .divRatio(divideRatioSel[0]),
    .speedSel(speedSelect[2:0]),
    .timeConst(tc0),
    .tick(brgTick[0])
  );

  baud_gen #() u_brg1 (
    .clk_sys(clk_sys),
    .reset(reset),
    .mode(ext1[BIT_BAUD_GEN_MODE]),
    .divRatio(divideRatioSel[1]),
    .speedSel(speedSelect[5:3]),
    .timeConst(tc1),
    .tick(brgTick[1])
  );

  // External clock pin is taken on its rising edge when the generator is off
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      srcTick[c] = (speedSelect[c*3 +: 3] == SS_EXTERNAL) ?
                   (serialClockPinIn[c] && !extClkPrev[c]) : brgTick[c];
    end
  end

  bit_clock_div u_div0 (
    .clk_sys(clk_sys),
    .reset(reset),
    .srcTick(srcTick[0]),
    .oneX(ext0[BIT_ONE_X]),
    .divRatio(divideRatioSel[0]),
    .bitTick(bitTickW[0])
  );

  bit_clock_div u_div1 (
    .clk_sys(clk_sys),
    .reset(reset),
    .srcTick(srcTick[1]),
    .oneX(ext1[BIT_ONE_X]),
    .divRatio(divideRatioSel[1]),
    .bitTick(bitTickW[1])
  );

  // Pin and status outputs, all registered
  always_comb begin
    clkToggle0 = serialClockPinOut[0] ^ brgTick[0];
    clkToggle1 = serialClockPinOut[1] ^ brgTick[1];
    // Clock pin out is a square wave toggling per generator tick
    clkOutNext = {clkToggle1, clkToggle0};
    clkOeNext[0] = speedSelect[2:0] != SS_EXTERNAL;
    clkOeNext[1] = speedSelect[5:3] != SS_EXTERNAL;
    // Break is held only as long as software leaves both bits set
    txPinNext[0] = (ext0[BIT_SEND_BRK] && ext0[BIT_BRK_EN]) ? 1'b0 : txSerialOut[0];
    txPinNext[1] = (ext1[BIT_SEND_BRK] && ext1[BIT_BRK_EN]) ? 1'b0 : txSerialOut[1];
    rxHoldNext = dcdHold || ioStopMode;
    txEmptyNext = txHoldingEmptyRaw && !(!ext0[BIT_CTS_DIS] && clearToSendInN);
    rxIntNext[0] = rxIntEnable0 && (dcdRiseSticky || next_framingErr[0] ||
                   (headValid[0] && (headOverrun[0] || headParityErr[0])));
    rxIntNext[1] = rxIntEnable1 && (next_framingErr[1] ||
                   (headValid[1] && (headOverrun[1] || headParityErr[1])));
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      extClkPrev <= '0;
      serialClockPinOut <= '0;
      serialClockPinOe <= '0;
      serialTxPin <= 2'h3;
      rxHoldReset0 <= 1'b1;
      txHoldingEmpty0 <= 1'b0;
      bitClockTick <= '0;
      breakDetectEnable <= '0;
      rxIntReq <= '0;
    end else begin
      extClkPrev <= serialClockPinIn;
      serialClockPinOut <= clkOutNext;
      serialClockPinOe <= clkOeNext;
      serialTxPin <= txPinNext;
      rxHoldReset0 <= rxHoldNext;
      txHoldingEmpty0 <= txEmptyNext;
      bitClockTick <= bitTickW;
      breakDetectEnable <= {ext1[BIT_BRK_EN], ext0[BIT_BRK_EN]};
      rxIntReq <= rxIntNext;
    end
  end
endmodule
`default_nettype wire

/* File: hw/serial_ext_pkg.sv */
// Constants for the serial extension control block
//
// Overview of operation
// - Carrier auto-enable on and carrier pin high holds channel 0 receiver in reset.
// - Carrier disable bit set makes carrier pin irrelevant to the receiver.
// - Carrier pin rising edge interrupts even with carrier disable set; pin level always readable in status.
// - Clear-to-send auto-enable on and pin high forces transmit-empty flag low.
// - Clear-to-send disable set ignores pin; pin level still readable in control B.
// - One-x mode uses generator or clock pin directly as bit clock.
// - Otherwise the clock is divided by 16 or 64 per divide-ratio bit.
// - Prescale mode divides system clock by 10 or 30 then a power of two.
// - Time-constant mode divides system clock by twice constant plus four.
// - Generator output feeds transmitter and receiver and may drive clock pin.
// - Break enable turns on break detection and break sending.
// - Break detect sets on all-zero framing-error character reaching FIFO head.
// - Break detect clears on error-flag write zero, reset, stop mode, carrier drop; carrier drop clears channel 0 only, with carrier auto-enable on.
// - Send break with break enable holds the transmit pin low.
// - Send break resets to zero; then transmit pin carries transmitter output.
// - Reset clears every extension control bit of both channels.
// - Receive interrupt enable gates carrier-rise and error interrupt requests.
// - Framing error flagged on zero stop bit once character is FIFO head.
package serial_ext_pkg;
  localparam logic [7:0] ADDR_EXT0 = 8'h00;
  localparam logic [7:0] ADDR_EXT1 = 8'h04;
  localparam logic [7:0] ADDR_TC0_LO = 8'h08;
  localparam logic [7:0] ADDR_TC0_HI = 8'h0c;
  localparam logic [7:0] ADDR_TC1_LO = 8'h10;
  localparam logic [7:0] ADDR_TC1_HI = 8'h14;
  localparam logic [7:0] ADDR_CTRL0 = 8'h18;
  localparam logic [7:0] ADDR_CTRL1 = 8'h1c;
  localparam logic [7:0] ADDR_STAT = 8'h20;
  localparam int BIT_DCD_DIS = 6;
  localparam int BIT_CTS_DIS = 5;
  localparam int BIT_ONE_X = 4;
  localparam int BIT_BAUD_GEN_MODE = 3;
  localparam int BIT_BRK_EN = 2;
  localparam int BIT_BRK_DET = 1;
  localparam int BIT_SEND_BRK = 0;
  localparam logic [7:0] EXT_RESET = 8'h00;
  localparam logic [2:0] SS_EXTERNAL = 3'h7;
  localparam logic [4:0] PRESCALE_LO = 5'h0a;
  localparam logic [4:0] PRESCALE_HI = 5'h1e;
  localparam int OVERSAMPLE_LO = 16;
  localparam int OVERSAMPLE_HI = 64;
  localparam logic [31:0] RESP_UNMAPPED = 32'h00000000;
endpackage

/* File: hw/baud_gen.sv */
// Baud generator: prescaler with power-of-two divider, or 16-bit time constant
`timescale 1ns/1ns
`default_nettype none
module baud_gen
  import serial_ext_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic mode,
  input wire logic divRatio,
  input wire logic [2:0] speedSel,
  input wire logic [15:0] timeConst,
  output logic tick
);
  logic [4:0] preCnt;
  logic [6:0] powCnt;
  // Eighteen bits: the longest constant gives a period beyond 17 bits
  logic [17:0] tcCnt;
  logic [4:0] next_preCnt;
  logic [6:0] next_powCnt;
  logic [17:0] next_tcCnt;
  logic next_tick;
  logic [4:0] preTop;
  logic [6:0] powTop;

  always_comb begin
    preTop = divRatio ? PRESCALE_HI : PRESCALE_LO;
    powTop = 7'((8'h01 << speedSel) - 8'h01);
    next_preCnt = preCnt;
    next_powCnt = powCnt;
    next_tcCnt = tcCnt;
    next_tick = 1'b0;
    if (speedSel == SS_EXTERNAL) begin
      next_preCnt = '0;
      next_powCnt = '0;
      next_tcCnt = '0;
    end else if (!mode) begin
      if (preCnt >= preTop - 5'h01) begin
        next_preCnt = '0;
        if (powCnt >= powTop) begin
          next_powCnt = '0;
          next_tick = 1'b1;
        end else begin
          next_powCnt = powCnt + 7'h01;
        end
      end else begin
        next_preCnt = preCnt + 5'h01;
      end
    end else begin
      // Constant is sampled only at reload, so mid-period writes do not glitch
      if (tcCnt == 18'h00000) begin
        next_tcCnt = 18'(({2'b00, timeConst} + 18'h00002) * 18'h00002 - 18'h00001);
        next_tick = 1'b1;
      end else begin
        next_tcCnt = tcCnt - 18'h00001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      preCnt <= '0;
      powCnt <= '0;
      tcCnt <= '0;
      tick <= 1'b0;
    end else begin
      preCnt <= next_preCnt;
      powCnt <= next_powCnt;
      tcCnt <= next_tcCnt;
      tick <= next_tick;
    end
  end
endmodule
`default_nettype wire

/* File: hw/bit_clock_div.sv */
// Bit clock divider: passes the source clock through or divides by 16 or 64
`timescale 1ns/1ns
`default_nettype none
module bit_clock_div
  import serial_ext_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic srcTick,
  input wire logic oneX,
  input wire logic divRatio,
  output logic bitTick
);
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic next_bitTick;
  logic [5:0] top;

  always_comb begin
    top = divRatio ? 6'(OVERSAMPLE_HI - 1) : 6'(OVERSAMPLE_LO - 1);
    next_cnt = cnt;
    next_bitTick = 1'b0;
    if (oneX) begin
      next_cnt = '0;
      next_bitTick = srcTick;
    end else if (srcTick) begin
      if (cnt >= top) begin
        next_cnt = '0;
        next_bitTick = 1'b1;
      end else begin
        next_cnt = cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cnt <= '0;
      bitTick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      bitTick <= next_bitTick;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/async_serial_ext_ctrl_brg_assertions.sv */
// Port-level assertions for the serial extension control block
`timescale 1ns/1ns
`default_nettype none
module serial_ext_checker
  import serial_ext_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic carrierDetectInN,
  input wire logic clearToSendInN,
  input wire logic ioStopMode,
  input wire logic rxIntEnable0,
  input wire logic [1:0] divideRatioSel,
  input wire logic [5:0] speedSelect,
  input wire logic [1:0] headValid,
  input wire logic [1:0] headStopZero,
  input wire logic [1:0] txSerialOut,
  input wire logic rxHoldReset0,
  input wire logic txHoldingEmpty0,
  input wire logic [1:0] serialTxPin,
  input wire logic [1:0] serialClockPinOe,
  input wire logic [1:0] bitClockTick,
  input wire logic [1:0] breakDetectEnable,
  input wire logic [1:0] framingErrFlag,
  input wire logic [1:0] rxIntReq
);
  // Shadow of channel 0 settings, taken when a write completes
  logic [6:0] ext0;
  logic [15:0] tc0, gap;
  logic [19:0] age;
  logic [3:0] cfgPast;
  logic [31:0] expGap;
  logic wrDone, brk0;
  assign wrDone = psel && penable && pready && pwrite && pstrb[0];
  assign brk0 = ext0[2] && ext0[0];
  always_comb begin
    expGap = (divideRatioSel[0] ? 32'd30 : 32'd10) << speedSelect[2:0];
    if (ext0[3]) expGap = (32'(tc0) + 32'd2) * 32'd2;
    if (!ext0[4]) expGap = expGap * (divideRatioSel[0] ? 32'd64 : 32'd16);
  end
  // The gap is only trusted once settings were still for several periods,
  // since a new constant waits for the next reload
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ext0 <= '0;
      tc0 <= '0;
      gap <= '0;
      age <= '0;
      cfgPast <= '0;
    end else begin
      cfgPast <= {speedSelect[2:0], divideRatioSel[0]};
      gap <= bitClockTick[0] ? 16'd1 : gap + 16'd1;
      age <= (wrDone || cfgPast != {speedSelect[2:0], divideRatioSel[0]}) ? 20'd0
        : (&age ? age : age + 20'd1);
      if (wrDone && paddr == ADDR_EXT0) ext0 <= pwdata[6:0] & 7'h7d;
      if (wrDone && paddr == ADDR_TC0_LO) tc0[7:0] <= pwdata[7:0];
      if (wrDone && paddr == ADDR_TC0_HI) tc0[15:8] <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  AST_RX_HOLD: assert property ((!ext0[6] && carrierDetectInN) [*5] |-> rxHoldReset0)
    else $error("receiver not held while carrier negated");
  AST_RX_FREE: assert property ((ext0[6] && !ioStopMode) [*2] |-> !rxHoldReset0)
    else $error("receiver held although carrier ignored");
  AST_INT_RISE: assert property (rxIntEnable0 && $rose(carrierDetectInN) |-> ##[1:5] rxIntReq[0])
    else $error("no interrupt on carrier rise");
  AST_TXE_GATE: assert property (!ext0[5] && clearToSendInN && $past(!ext0[5] && clearToSendInN)
    |-> !txHoldingEmpty0)
    else $error("transmit empty not forced low");
  AST_BIT_PERIOD: assert property (bitClockTick[0] && speedSelect[2:0] != SS_EXTERNAL
    && 32'(age) > 32'd4 * expGap |-> 32'(gap) == expGap)
    else $error("bit clock period wrong");
  AST_CLK_OE: assert property (1'b1 |=> serialClockPinOe[0] == ($past(speedSelect[2:0]) != SS_EXTERNAL))
    else $error("clock pin drive wrong");
  AST_BRK_EN: assert property (ext0[2] && $past(ext0[2]) |-> breakDetectEnable[0])
    else $error("break detection not enabled");
  AST_TX_BREAK: assert property (brk0 && $past(brk0) |-> !serialTxPin[0])
    else $error("transmit pin not held low in break");
  AST_TX_PASS: assert property (!brk0 && $past(!brk0) |-> serialTxPin[0] == $past(txSerialOut[0]))
    else $error("transmit pin not following transmitter");
  AST_FE_SET: assert property (headValid[0] && headStopZero[0] && !ioStopMode
    |-> ##[1:2] framingErrFlag[0])
    else $error("framing error not flagged");
  cover property (brk0 && !serialTxPin[0]);
  cover property (rxHoldReset0 && !ext0[6]);
  cover property (rxIntReq[0] && framingErrFlag[0]);
endmodule
bind async_serial_ext_ctrl_brg serial_ext_checker checker_i (.*);
`default_nettype wire

/* File: testbench/remote_modem.sv */
// Remote modem model: carrier, clear-to-send and an external bit clock
`timescale 1ns/1ns
`default_nettype none
module remote_modem #(
  parameter int HALF = 4
) (
  input wire logic clk_sys,
  input wire logic carrierOn,
  input wire logic ctsOn,
  input wire logic clockRun,
  output logic carrierDetectInN,
  output logic clearToSendInN,
  output logic serialClockPin
);
  int halfCnt;
  always @(posedge clk_sys) begin
    carrierDetectInN <= !carrierOn;
    clearToSendInN <= !ctsOn;
    // Clock stands low between frames so no stray edge reaches the bit clock divider
    if (!clockRun) begin
      serialClockPin <= 1'b0;
      halfCnt <= 0;
    end else if (halfCnt == HALF - 1) begin
      serialClockPin <= !serialClockPin;
      halfCnt <= 0;
    end else begin
      halfCnt <= halfCnt + 1;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/async_serial_ext_ctrl_brg_bench.sv */
// Self-checking bench for the serial extension control block
`timescale 1ns/1ns
`default_nettype none
module async_serial_ext_ctrl_brg_bench
  import serial_ext_pkg::*;
;
  logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, lastErr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] pstrb;
  logic ioStopMode, errorFlagResetWr0, errorFlagResetWr1, rxIntEnable0, rxIntEnable1;
  logic [5:0] speedSelect;
  logic [15:0] headData;
  logic [1:0] divideRatioSel, serialClockPinIn, headValid, headStopZero, headOverrun;
  logic [1:0] headParityErr, txSerialOut, serialTxPin, serialClockPinOut, serialClockPinOe;
  logic [1:0] bitClockTick, breakDetectEnable, framingErrFlag, rxIntReq;
  logic txHoldingEmptyRaw, carrierDetectInN, clearToSendInN, rxHoldReset0, txHoldingEmpty0;
  logic modemClk, carrierOn, ctsOn, clockRun, clkSeen;
  int err_count = 0;
  int check_count = 0;
  assign serialClockPinIn = {1'b0, modemClk};
  async_serial_ext_ctrl_brg dut (.*);
  remote_modem modem (.clk_sys(clk_sys), .carrierOn(carrierOn), .ctsOn(ctsOn),
    .clockRun(clockRun), .carrierDetectInN(carrierDetectInN),
    .clearToSendInN(clearToSendInN), .serialClockPin(modemClk));
  task automatic end_sim();
    if (err_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    lastErr = pslverr;
    if (pready !== 1'b1) err_count++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(q, e);
  endtask
  task automatic char0(input logic [7:0] d);
    headData <= {8'h00, d};
    headStopZero <= 2'b01;
    headValid <= 2'b01;
    @(posedge clk_sys);
    headValid <= 2'b00;
    headStopZero <= 2'b00;
    cyc(3);
  endtask
  task automatic error_flag_reset();
    errorFlagResetWr0 <= 1'b1;
    errorFlagResetWr1 <= 1'b1;
    @(posedge clk_sys);
    errorFlagResetWr0 <= 1'b0;
    errorFlagResetWr1 <= 1'b0;
    cyc(2);
  endtask
  // Skips early gaps, which may still carry the previous setting
  task automatic tick_gap(input int ch, input logic [31:0] exp);
    int n, g;
    n = 0;
    g = 0;
    repeat (4) begin
      g = 0;
      do begin
        @(posedge clk_sys);
        g++;
        n++;
      end while (bitClockTick[ch] !== 1'b1 && n < 3000);
    end
    check(32'(g), exp);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_count++;
    end_sim();
  end
  initial begin
    {reset, pstrb, speedSelect, txSerialOut, txHoldingEmptyRaw} = {1'b1, 4'hf, 6'h3f, 3'h7};
    {psel, penable, pwrite, paddr, pwdata, ioStopMode, divideRatioSel} = '0;
    {errorFlagResetWr0, errorFlagResetWr1, rxIntEnable0, rxIntEnable1} = '0;
    {headValid, headData, headStopZero, headOverrun, headParityErr} = '0;
    {carrierOn, ctsOn, clockRun} = '0;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    rdc(ADDR_EXT0, 32'h0);
    rdc(ADDR_EXT1, 32'h0);
    check(serialTxPin, 2'h3);
    rdc(8'h40, 32'h0);
    check(lastErr, 1'h1);
    apb(1'b1, ADDR_EXT0, 32'hff);
    apb(1'b1, ADDR_EXT1, 32'hff);
    rdc(ADDR_EXT0, 32'h7d);
    rdc(ADDR_EXT1, 32'h1d);
    check(serialTxPin, 2'h0);
    apb(1'b1, ADDR_EXT0, 32'h01);
    apb(1'b1, ADDR_EXT1, 32'h1c);
    txSerialOut <= 2'b10;
    cyc(3);
    check(serialTxPin, 2'h2);
    apb(1'b1, ADDR_EXT0, 32'h00);
    cyc(3);
    check(rxHoldReset0, 1'h1);
    check(txHoldingEmpty0, 1'h0);
    rdc(ADDR_CTRL0, 32'h1);
    apb(1'b1, ADDR_EXT0, 32'h60);
    cyc(3);
    check(rxHoldReset0, 1'h0);
    check(txHoldingEmpty0, 1'h1);
    ctsOn <= 1'b1;
    carrierOn <= 1'b1;
    cyc(6);
    rdc(ADDR_CTRL0, 32'h0);
    apb(1'b0, ADDR_STAT, 32'h0);
    carrierOn <= 1'b0;
    cyc(6);
    check(rxIntReq[0], 1'h0);
    rxIntEnable0 <= 1'b1;
    rxIntEnable1 <= 1'b1;
    cyc(2);
    check(rxIntReq[0], 1'h1);
    rdc(ADDR_STAT, 32'h7);
    cyc(2);
    check(rxIntReq[0], 1'h0);
    check(rxHoldReset0, 1'h0);
    carrierOn <= 1'b1;
    cyc(6);
    carrierOn <= 1'b0;
    cyc(8);
    check(rxIntReq[0], 1'h1);
    headValid <= 2'b10;
    headOverrun <= 2'b10;
    cyc(1);
    headValid <= 2'b00;
    cyc(1);
    check(rxIntReq[1], 1'h1);
    apb(1'b1, ADDR_EXT0, 32'h44);
    char0(8'h00);
    rdc(ADDR_EXT0, 32'h46);
    check(framingErrFlag[0], 1'h1);
    check(rxIntReq[0], 1'h1);
    error_flag_reset();
    rdc(ADDR_EXT0, 32'h44);
    char0(8'h01);
    rdc(ADDR_EXT0, 32'h44);
    apb(1'b1, ADDR_EXT0, 32'h40);
    char0(8'h00);
    rdc(ADDR_EXT0, 32'h40);
    apb(1'b1, ADDR_EXT0, 32'h44);
    char0(8'h00);
    ioStopMode <= 1'b1;
    cyc(2);
    ioStopMode <= 1'b0;
    rdc(ADDR_EXT0, 32'h44);
    char0(8'h00);
    apb(1'b1, ADDR_EXT0, 32'h04);
    cyc(6);
    rdc(ADDR_EXT0, 32'h04);
    apb(1'b1, ADDR_TC0_LO, 32'h03);
    apb(1'b1, ADDR_TC0_HI, 32'h00);
    apb(1'b1, ADDR_EXT0, 32'h58);
    speedSelect <= 6'h00;
    tick_gap(0, 32'd10);
    clkSeen = serialClockPinOut[0];
    cyc(10);
    check(serialClockPinOut[0], !clkSeen);
    apb(1'b1, ADDR_EXT0, 32'h50);
    speedSelect <= 6'h01;
    divideRatioSel <= 2'b01;
    tick_gap(0, 32'd60);
    apb(1'b1, ADDR_TC0_LO, 32'h00);
    apb(1'b1, ADDR_EXT0, 32'h48);
    divideRatioSel <= 2'b00;
    tick_gap(0, 32'd64);
    apb(1'b1, ADDR_TC1_LO, 32'h00);
    apb(1'b1, ADDR_EXT1, 32'h08);
    divideRatioSel <= 2'b10;
    tick_gap(1, 32'd256);
    apb(1'b1, ADDR_TC0_HI, 32'h01);
    apb(1'b1, ADDR_EXT0, 32'h58);
    tick_gap(0, 32'd516);
    apb(1'b1, ADDR_EXT0, 32'h50);
    speedSelect <= 6'h07;
    clockRun <= 1'b1;
    tick_gap(0, 32'd8);
    check(serialClockPinOe[0], 1'h0);
    clockRun <= 1'b0;
    cyc(2);
    end_sim();
  end
endmodule
`default_nettype wire
